// file: hw/mps_sequencer.v
// Motion procedure sequencer: homing setup, step chaining, blending, insertion
// Contract
// R1: Path field zero halts, 1..63 runs step
// R2: Ramp-up select picks homing acceleration time
// R3: First slowdown select picks stage-one deceleration
// R4: Stop ramp time is stage-two deceleration
// R5: Wait select picks one of sixteen delays
// R6: Boot field one homes at first servo-on
// R7: Signed home coordinate preset at origin
// R8: Path zero: stop, never return to origin
// R9: Index coordinate spans 0 to 1048575 pulses
// R10: Sixty-three steps, five procedure types
// R11: Chain/insert all types, blend positioning only
// R12: Chained step starts after completion plus delay
// R13: Chain delay counts from target reached
// R14: Blend overlaps deceleration with next acceleration
// R15: Software: blended step no delay, matched ramps
// R16: Insert flag on next step cuts previous
// R17: Internal insert delay counts from previous start
// R18: External insert discards pending, ignores delays
// R19: External non-insert step waits for completion
// R20: Unused setup word bits are ignored
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "mps_consts.vh"
module mps_sequencer (
  input wire clk_sys,
  input wire arst_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire origin_seen,
  input wire in_target,
  input wire decel_zone,
  input wire motion_idle,
  input wire ext_trigger,
  input wire [5:0] ext_step,
  output reg home_run,
  output reg [15:0] ramp_up_time,
  output reg [15:0] ramp_down_time,
  output reg [15:0] stop_ramp_time,
  output reg preset_valid,
  output reg [31:0] preset_value,
  output reg move_start,
  output reg [3:0] move_kind,
  output reg [19:0] move_target,
  output reg move_blend,
  output reg move_cut
);
  localparam S_IDLE = 3'd0;
  localparam S_HOME = 3'd1;
  localparam S_HSTOP = 3'd2;
  localparam S_ISSUE = 3'd3;
  localparam S_RUN = 3'd4;
  localparam S_WAIT = 3'd5;

  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge_be = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge_be[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function [3:0] nib;
    input [31:0] w;
    input integer lsb;
    begin
      nib = w[lsb +: 4];
    end
  endfunction

  // ======================================================================
  // Storage
  reg [31:0] home_setup_word;
  reg [31:0] home_origin_word;
  reg [31:0] step_mem [0:63];
  reg [15:0] time_mem [0:31];
  reg servo_on;
  reg sw_home_go;
  reg sw_step_go;
  reg [5:0] sw_step;
  reg [2:0] st;
  reg [5:0] cur;
  reg pend_valid;
  reg [5:0] pend_step;
  reg home_done;
  reg boot_used;
  reg son_q;
  reg cut_flag;
  reg blend_flag;
  reg ins_armed;
  reg [1:0] run_age;
  reg tmr_start;
  reg [15:0] tmr_load;
  wire tmr_done;
  wire tmr_busy;

  // ======================================================================
  // Pin synchronisers and edge detect
  wire [10:0] pins_q;
  reg origin_q;
  reg ext_q;
  mps_sync #(.W(11)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d({ext_step, ext_trigger, motion_idle, decel_zone, in_target, origin_seen}),
    .q(pins_q)
  );
  wire origin_s = pins_q[0];
  wire target_s = pins_q[1];
  wire decel_s = pins_q[2];
  wire idle_s = pins_q[3];
  wire ext_s = pins_q[4];
  wire [5:0] ext_step_s = pins_q[10:5];
  wire origin_rise = origin_s & ~origin_q;
  wire ext_rise = ext_s & ~ext_q;

  mps_wait_timer #(.W(16)) u_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done),
    .busy(tmr_busy)
  );

  // ======================================================================
  // Step decode
  wire [5:0] nxt = cur + 6'h01;
  wire [31:0] cur_w = step_mem[cur];
  wire [31:0] nxt_w = step_mem[nxt];
  wire [31:0] ext_w = step_mem[ext_step_s];
  wire [3:0] cur_type = nib(cur_w, `MPS_F_TYPE);
  wire has_next = cur_w[`MPS_F_CHAIN] && (cur != `MPS_LAST_STEP);
  wire [15:0] cur_wait = time_mem[{1'b1, nib(cur_w, `MPS_F_WAIT)}];
  // R11 blend only between two positioning steps
  wire blend_ok = has_next && cur_w[`MPS_F_BLEND] && (cur_type == `MPS_T_POS) &&
    (nib(nxt_w, `MPS_F_TYPE) == `MPS_T_POS);
  // R20 only the path, select and boot fields are decoded
  wire [7:0] path = home_setup_word[`MPS_F_PATH +: 8];
  wire [3:0] boot = nib(home_setup_word, `MPS_F_BOOT);

  // ======================================================================
  // Sequencer state machine
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= S_IDLE;
      cur <= 6'h00;
      pend_valid <= 1'b0;
      pend_step <= 6'h00;
      home_done <= 1'b0;
      boot_used <= 1'b0;
      son_q <= 1'b0;
      origin_q <= 1'b0;
      ext_q <= 1'b0;
      cut_flag <= 1'b0;
      blend_flag <= 1'b0;
      ins_armed <= 1'b0;
      tmr_start <= 1'b0;
      tmr_load <= 16'h0000;
      run_age <= 2'h0;
      home_run <= 1'b0;
      ramp_up_time <= 16'h0000;
      ramp_down_time <= 16'h0000;
      preset_valid <= 1'b0;
      preset_value <= 32'h0000_0000;
      move_start <= 1'b0;
      move_kind <= 4'h0;
      move_target <= 20'h00000;
      move_blend <= 1'b0;
      move_cut <= 1'b0;
    end else begin
      son_q <= servo_on;
      origin_q <= origin_s;
      ext_q <= ext_s;
      tmr_start <= 1'b0;
      preset_valid <= 1'b0;
      move_start <= 1'b0;
      case (st)
        S_IDLE: begin
          ins_armed <= 1'b0;
          if (servo_on && !son_q) begin
            boot_used <= 1'b1;
          end
          // R6 boot homing only on the first servo-on
          if ((servo_on && !son_q && !boot_used && boot == `MPS_BOOT_RUN) ||
              (sw_home_go && servo_on)) begin
            st <= S_HOME;
            home_done <= 1'b0;
          end else if (sw_step_go && servo_on && sw_step != 6'h00) begin
            cur <= sw_step;
            cut_flag <= 1'b0;
            blend_flag <= 1'b0;
            st <= S_ISSUE;
          end
        end
        S_HOME: begin
          home_run <= 1'b1;
          // R2 acceleration select
          ramp_up_time <= time_mem[{1'b0, nib(home_setup_word, `MPS_F_ACC)}];
          // R3 first slowdown select
          ramp_down_time <= time_mem[{1'b0, nib(home_setup_word, `MPS_F_FIRST_SLOWDOWN_SELECT)}];
          if (origin_rise) begin
            // R7 signed home coordinate
            preset_valid <= 1'b1;
            preset_value <= home_origin_word;
            // R4 stop ramp for stage two
            ramp_down_time <= stop_ramp_time;
            st <= S_HSTOP;
          end
        end
        S_HSTOP: begin
          // R8 coast to rest, no return move
          if (idle_s) begin
            home_run <= 1'b0;
            home_done <= 1'b1;
            // R1 path selects follow-on step
            if (path != 8'h00 && path <= {2'b00, `MPS_LAST_STEP}) begin
              cur <= path[5:0];
              cut_flag <= 1'b0;
              blend_flag <= 1'b0;
              st <= S_ISSUE;
            end else begin
              st <= S_IDLE;
            end
          end
        end
        S_ISSUE: begin
          ins_armed <= 1'b0;
          run_age <= 2'h0;
          // R10 five step types
          case (cur_type)
            `MPS_T_JUMP: begin
              if (cur_w[`MPS_F_TGT +: 6] == 6'h00) begin
                st <= S_IDLE;
              end else begin
                cur <= cur_w[`MPS_F_TGT +: 6];
              end
            end
            `MPS_T_SPEED, `MPS_T_POS, `MPS_T_INDEX: begin
              // R9 twenty-bit index coordinate
              move_start <= 1'b1;
              move_kind <= cur_type;
              move_target <= cur_w[`MPS_F_TGT +: 20];
              move_blend <= blend_flag;
              move_cut <= cut_flag;
              st <= S_RUN;
              // R17 insert delay starts with this step
              if (has_next && nxt_w[`MPS_F_INS]) begin
                ins_armed <= 1'b1;
                tmr_start <= 1'b1;
                tmr_load <= cur_wait;
              end
            end
            default: begin
              // Parameter write and unknown types complete at once
              tmr_start <= 1'b1;
              tmr_load <= cur_wait;
              st <= S_WAIT;
            end
          endcase
          cut_flag <= 1'b0;
          blend_flag <= 1'b0;
        end
        S_RUN: begin
          if (ins_armed && tmr_done) begin
            // R16 next step cuts this one short
            cur <= nxt;
            cut_flag <= 1'b1;
            st <= S_ISSUE;
          end else if (run_age != `MPS_RUN_SETTLE) begin
            // Feedback lags a pin round trip; stale in-target would end the move
            run_age <= run_age + 2'h1;
          end else if (blend_ok && decel_s) begin
            // R14 next move starts inside our slowdown
            cur <= nxt;
            blend_flag <= 1'b1;
            st <= S_ISSUE;
          end else if (target_s) begin
            if (pend_valid) begin
              // R19 queued external step after completion
              cur <= pend_step;
              pend_valid <= 1'b0;
              st <= S_ISSUE;
            end else if (!ins_armed) begin
              // R13 delay counts from target reached
              tmr_start <= 1'b1;
              tmr_load <= cur_wait;
              st <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (tmr_done) begin
            // R12 chain after completion plus delay
            if (pend_valid) begin
              cur <= pend_step;
              pend_valid <= 1'b0;
              st <= S_ISSUE;
            end else if (has_next) begin
              cur <= nxt;
              st <= S_ISSUE;
            end else begin
              st <= S_IDLE;
            end
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
      // External trigger overrides the step flow
      if (ext_rise && servo_on && ext_step_s != 6'h00 &&
          st != S_HOME && st != S_HSTOP) begin
        if (ext_w[`MPS_F_INS] || st == S_IDLE) begin
          // R18 discard queue and pending delays
          cur <= ext_step_s;
          cut_flag <= (st != S_IDLE);
          blend_flag <= 1'b0;
          pend_valid <= 1'b0;
          ins_armed <= 1'b0;
          tmr_start <= 1'b0;
          st <= S_ISSUE;
        end else begin
          // R19 hold until current step completes
          pend_valid <= 1'b1;
          pend_step <= ext_step_s;
        end
      end
      // Servo off abandons any sequence
      if (!servo_on && st != S_IDLE) begin
        st <= S_IDLE;
        home_run <= 1'b0;
        pend_valid <= 1'b0;
      end
    end
  end

  // ======================================================================
  // AXI4-Lite slave; write taken only with address and data together
  wire [11:0] wa = s_axi_awaddr;
  wire [11:0] ra = s_axi_araddr;
  wire w_step = (wa[11:8] == `MPS_OFF_STEP_PAGE) && (wa[7:2] != 6'h00);
  wire w_time = (wa[11:8] == `MPS_OFF_TIME_PAGE) && (wa[7] == 1'b0);
  wire w_ok = w_step || w_time || wa == `MPS_OFF_SETUP || wa == `MPS_OFF_ORIGIN ||
    wa == `MPS_OFF_CTRL || wa == `MPS_OFF_STOPRAMP;
  wire r_step = (ra[11:8] == `MPS_OFF_STEP_PAGE);
  wire r_time = (ra[11:8] == `MPS_OFF_TIME_PAGE) && (ra[7] == 1'b0);
  wire w_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire r_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  wire [31:0] ctrl_rd = {18'h00000, sw_step, 7'h00, servo_on};
  wire [31:0] stat_rd = {14'h0000, home_done, pend_valid, 2'b00, cur, 5'h00, st};
  wire [31:0] time_wr = merge_be({16'h0000, time_mem[wa[6:2]]}, s_axi_wdata, s_axi_wstrb);
  reg [31:0] rd_mux;
  reg rd_err;
  integer k;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (r_step) begin
      rd_mux = step_mem[ra[7:2]];
    end else if (r_time) begin
      rd_mux = {16'h0000, time_mem[ra[6:2]]};
    end else begin
      case (ra)
        `MPS_OFF_SETUP: rd_mux = home_setup_word;
        `MPS_OFF_ORIGIN: rd_mux = home_origin_word;
        `MPS_OFF_CTRL: rd_mux = ctrl_rd;
        `MPS_OFF_STATUS: rd_mux = stat_rd;
        `MPS_OFF_STOPRAMP: rd_mux = {16'h0000, stop_ramp_time};
        default: rd_err = 1'b1;
      endcase
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MPS_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `MPS_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      stop_ramp_time <= `MPS_RST_STOPRAMP;
      home_setup_word <= `MPS_RST_SETUP;
      home_origin_word <= `MPS_RST_ORIGIN;
      servo_on <= 1'b0;
      sw_home_go <= 1'b0;
      sw_step_go <= 1'b0;
      sw_step <= 6'h00;
      for (k = 0; k < 64; k = k + 1) begin
        step_mem[k] <= 32'h0000_0000;
      end
      for (k = 0; k < 32; k = k + 1) begin
        time_mem[k] <= 16'h0000;
      end
    end else begin
      s_axi_awready <= w_go;
      s_axi_wready <= w_go;
      s_axi_arready <= r_go;
      sw_home_go <= 1'b0;
      sw_step_go <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (w_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? `MPS_RESP_OK : `MPS_RESP_ERR;
        if (w_step) begin
          step_mem[wa[7:2]] <= merge_be(step_mem[wa[7:2]], s_axi_wdata, s_axi_wstrb);
        end
        if (w_time) begin
          time_mem[wa[6:2]] <= time_wr[15:0];
        end
        case (wa)
          `MPS_OFF_SETUP: home_setup_word <= merge_be(home_setup_word, s_axi_wdata,
            s_axi_wstrb);
          `MPS_OFF_ORIGIN: home_origin_word <= merge_be(home_origin_word, s_axi_wdata,
            s_axi_wstrb);
          `MPS_OFF_STOPRAMP: stop_ramp_time <= s_axi_wdata[15:0];
          `MPS_OFF_CTRL: begin
            if (s_axi_wstrb[0]) begin
              servo_on <= s_axi_wdata[`MPS_C_SON];
              sw_home_go <= s_axi_wdata[`MPS_C_HOME];
              sw_step_go <= s_axi_wdata[`MPS_C_GO];
            end
            if (s_axi_wstrb[1]) begin
              sw_step <= s_axi_wdata[`MPS_C_STEP +: 6];
            end
          end
          default: begin
          end
        endcase
      end
      if (r_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_err ? `MPS_RESP_ERR : `MPS_RESP_OK;
      end
    end
  end
endmodule

// file: hw/mps_consts.vh
// Register map, field layout and reset values of the motion procedure sequencer
`ifndef MPS_CONSTS_VH
`define MPS_CONSTS_VH
// ======================================================================
// Register byte offsets
`define MPS_OFF_SETUP 12'h000
`define MPS_OFF_ORIGIN 12'h004
`define MPS_OFF_CTRL 12'h008
`define MPS_OFF_STATUS 12'h00c
`define MPS_OFF_STOPRAMP 12'h010
`define MPS_OFF_STEP_PAGE 4'h1
`define MPS_OFF_TIME_PAGE 4'h2
// ======================================================================
// Reset values
`define MPS_RST_SETUP 32'h0000_0000
`define MPS_RST_ORIGIN 32'h0000_0000
`define MPS_RST_STOPRAMP 16'h0000
// ======================================================================
// Home setup word fields
`define MPS_F_PATH 0
`define MPS_F_ACC 8
`define MPS_F_FIRST_SLOWDOWN_SELECT 12
`define MPS_F_DLY 20
`define MPS_F_BOOT 28
`define MPS_BOOT_RUN 4'h1
// ======================================================================
// Stored step word fields
`define MPS_F_TYPE 0
`define MPS_F_INS 4
`define MPS_F_BLEND 5
`define MPS_F_CHAIN 6
`define MPS_F_WAIT 8
`define MPS_F_TGT 12
`define MPS_T_SPEED 4'h1
`define MPS_T_POS 4'h2
`define MPS_T_JUMP 4'h3
`define MPS_T_PWRITE 4'h8
`define MPS_T_INDEX 4'ha
// ======================================================================
// Control and status fields
`define MPS_C_SON 0
`define MPS_C_HOME 1
`define MPS_C_GO 2
`define MPS_C_STEP 8
`define MPS_S_PEND 16
`define MPS_S_HDONE 17
`define MPS_WAIT_BASE 5'h10
`define MPS_LAST_STEP 6'h3f
`define MPS_RUN_SETTLE 2'h3
`define MPS_RESP_OK 2'b00
`define MPS_RESP_ERR 2'b10
`endif

// file: hw/mps_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module mps_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: hw/mps_wait_timer.v
// Down-counter for step delays; done pulses once when the count runs out
`timescale 1ns/10ps
module mps_wait_timer #(
  parameter W = 16
) (
  input wire clk_sys,
  input wire arst_n,
  input wire start,
  input wire [W-1:0] load,
  output reg done,
  output reg busy
);
  reg [W-1:0] cnt;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= load;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt == {W{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// file: dv/mps_seq_sva.sv
// Port assertions for the motion procedure sequencer
`timescale 1ns/10ps
`include "mps_consts.vh"
module mps_seq_sva (
  input wire clk_sys,
  input wire arst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire origin_seen,
  input wire home_run,
  input wire [15:0] stop_ramp_time,
  input wire [15:0] ramp_down_time,
  input wire preset_valid,
  input wire move_start,
  input wire [3:0] move_kind,
  input wire [19:0] move_target,
  input wire move_blend,
  input wire move_cut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ======================================================================
  // Bus handshakes
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  endsequence
  sequence wr_ack;
    s_axi_awready && s_axi_wready && s_axi_bvalid;
  endsequence
  write_ack_a: assert property (wr_take |=> wr_ack) else $error("write not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  read_ack_a: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  // ======================================================================
  // Homing and moves
  preset_pulse_a: assert property (preset_valid |=> !preset_valid)
    else $error("preset longer than one cycle");
  preset_origin_a: assert property (home_run && $rose(origin_seen) |-> ##[1:8] preset_valid)
    else $error("no preset after origin");
  home_quiet_a: assert property (home_run |-> !move_start)
    else $error("step started during homing");
  move_hold_a: assert property (!move_start |->
    $stable({move_kind, move_target, move_blend, move_cut})) else $error("move fields moved");
  blend_pos_a: assert property (move_start && move_blend |-> move_kind == `MPS_T_POS)
    else $error("blend on non-positioning move");
  stop_port_a: assert property (preset_valid |-> ramp_down_time == stop_ramp_time)
    else $error("stage two slowdown not stop ramp");
endmodule
bind mps_sequencer mps_seq_sva u_mps_seq_sva (.*);

// file: dv/mps_motor_model.sv
// Behavioural motor stage and position feedback for the sequencer bench
`timescale 1ns/10ps
module mps_motor_model (
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] len,
  input wire home_run,
  input wire move_start,
  output logic origin_seen,
  output logic in_target,
  output logic decel_zone,
  output logic motion_idle
);
  logic hr_d;
  logic busy;
  logic [7:0] cnt;
  // Move lasts len+1 cycles; slowdown shown over the last fifteen
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hr_d <= 1'h0;
      busy <= 1'h0;
      cnt <= 8'h00;
      origin_seen <= 1'h0;
      in_target <= 1'h0;
      decel_zone <= 1'h0;
      motion_idle <= 1'h1;
    end else begin
      hr_d <= home_run;
      // Held four cycles so the two-stage sync cannot miss it
      origin_seen <= busy && home_run && cnt >= 8'h05 && cnt < 8'h09;
      if (move_start || (home_run && !hr_d)) begin
        busy <= 1'h1;
        cnt <= 8'h00;
        in_target <= 1'h0;
        decel_zone <= 1'h0;
        motion_idle <= 1'h0;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
        decel_zone <= cnt >= len - 8'h0f;
        if (cnt == len) begin
          busy <= 1'h0;
          in_target <= 1'h1;
          motion_idle <= 1'h1;
          decel_zone <= 1'h0;
        end
      end
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the motion procedure sequencer
`timescale 1ns/10ps
`include "mps_consts.vh"
module testbench;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, ext_trigger = 1'h0;
  logic [5:0] ext_step = 6'h00;
  logic [7:0] len = 8'h28;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, preset_value;
  wire origin_seen, in_target, decel_zone, motion_idle, home_run, preset_valid;
  wire move_start, move_blend, move_cut;
  wire [15:0] ramp_up_time, ramp_down_time, stop_ramp_time;
  wire [3:0] move_kind;
  wire [19:0] move_target;
  int error_cnt = 0;
  int n_checks = 0;
  mps_sequencer u_mps_sequencer (.*);
  mps_motor_model u_mps_motor_model (.*);
  initial forever #20 clk_sys = ~clk_sys;
  // ======================================================================
  // Shared tasks
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task automatic tmo(input string nm);
    error_cnt++;
    $display("unexpected %s exp answer got timeout", nm);
    final_report();
  endtask
  task automatic do_reset();
    arst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] er = `MPS_RESP_OK);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (i == 40) tmo("write");
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
      input logic [1:0] er = `MPS_RESP_OK);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (i == 40) tmo("read");
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk("rdata", ed, s_axi_rdata);
    @(posedge clk_sys);
  endtask
  // Flag 0 homing, 1 preset, 2 move start
  task automatic wait_flag(input int k, output int n);
    for (n = 1; n < 300; n++) begin
      @(posedge clk_sys);
      if ((k == 0 ? home_run : k == 1 ? preset_valid : move_start) === 1'h1) return;
    end
    tmo("flag");
  endtask
  // ======================================================================
  // Scenarios
  task automatic t_regs();
    rd(`MPS_OFF_SETUP, `MPS_RST_SETUP);
    rd(`MPS_OFF_ORIGIN, `MPS_RST_ORIGIN);
    wr(`MPS_OFF_ORIGIN, 32'h8000_0001);
    rd(`MPS_OFF_ORIGIN, 32'h8000_0001);
    wr(12'h1fc, 32'h0400_0043);
    rd(12'h1fc, 32'h0400_0043);
    wr(12'h100, 32'h0000_0002, `MPS_RESP_ERR);
    rd(12'h3f0, 32'h0, `MPS_RESP_ERR);
  endtask
  task automatic t_boot_off();
    wr(`MPS_OFF_SETUP, 32'h0000_5300);
    wr(`MPS_OFF_CTRL, 32'h1);
    repeat (40) @(posedge clk_sys);
    chk("home_run", 32'h0, {31'h0, home_run});
    wr(`MPS_OFF_CTRL, 32'h0);
  endtask
  task automatic t_home();
    int n;
    for (int i = 0; i < 16; i++) wr({4'h2, 1'h0, i[4:0], 2'h0}, 32'h0100 + i);
    wr(12'h244, 32'h000a);
    wr(12'h248, 32'h0014);
    wr(12'h104, 32'h1234_5242);
    wr(12'h108, 32'hffff_f00a);
    wr(12'h10c, 32'h0010_0062);
    wr(12'h110, 32'h0020_0002);
    wr(12'h114, 32'h0055_5001);
    wr(12'h118, 32'h0030_0142);
    wr(12'h11c, 32'h0040_0012);
    wr(12'h120, 32'h0008_0061);
    wr(12'h124, 32'h0090_0002);
    wr(12'h128, 32'h0063_4008);
    wr(`MPS_OFF_STOPRAMP, 32'h0777);
    wr(`MPS_OFF_ORIGIN, 32'h8000_0001);
    wr(`MPS_OFF_SETUP, 32'h1000_5300);
    wr(`MPS_OFF_CTRL, 32'h1);
    wait_flag(0, n);
    chk("ramp_up", 32'h0103, {16'h0, ramp_up_time});
    chk("ramp_down", 32'h0105, {16'h0, ramp_down_time});
    wait_flag(1, n);
    chk("preset", 32'h8000_0001, preset_value);
    repeat (3) @(posedge clk_sys);
    chk("stop ramp", 32'h0777, {16'h0, ramp_down_time});
    for (n = 0; n < 120 && move_start !== 1'h1; n++) @(posedge clk_sys);
    chk("idle after home", 32'd120, n);
    len <= 8'h10;
    wr(`MPS_OFF_SETUP, 32'h0f0f_5305);
    wr(`MPS_OFF_CTRL, 32'h3);
    wait_flag(2, n);
    chk("path move", {8'h0, `MPS_T_SPEED, 20'h00555}, {8'h0, move_kind, move_target});
    len <= 8'h28;
    repeat (80) @(posedge clk_sys);
  endtask
  // Start step s, optionally trigger step e, time the next move
  task automatic t_link(input logic [5:0] s, input logic [5:0] e, input int lo, input int hi,
      input logic [3:0] k, input logic [19:0] t, input logic c);
    int n;
    wr(`MPS_OFF_CTRL, {18'h0, s, 8'h05});
    wait_flag(2, n);
    if (e != 6'h00) begin
      repeat (3) @(posedge clk_sys);
      ext_step <= e;
      ext_trigger <= 1'h1;
    end
    wait_flag(2, n);
    ext_trigger <= 1'h0;
    chk_rng("gap", lo, hi, n);
    chk("move", {8'h0, k, t}, {8'h0, move_kind, move_target});
    chk("cut", {31'h0, c}, {31'h0, move_cut});
    repeat (150) @(posedge clk_sys);
  endtask
  // ======================================================================
  // Main sequence
  initial begin
    do_reset();
    t_regs();
    t_boot_off();
    do_reset();
    t_home();
    t_link(6'h01, 6'h00, 62, 80, `MPS_T_INDEX, 20'hfffff, 1'h0);
    t_link(6'h03, 6'h00, 1, 40, `MPS_T_POS, 20'h00200, 1'h0);
    t_link(6'h08, 6'h00, 41, 60, `MPS_T_POS, 20'h00900, 1'h0);
    t_link(6'h06, 6'h00, 11, 24, `MPS_T_POS, 20'h00400, 1'h1);
    t_link(6'h02, 6'h07, 2, 14, `MPS_T_POS, 20'h00400, 1'h1);
    t_link(6'h02, 6'h04, 36, 52, `MPS_T_POS, 20'h00200, 1'h0);
    final_report();
  end
endmodule
